// file: design/asq_input_decode.v
// Decode of one step's gain and input fields into converter controls.
`default_nettype none
`include "asq_defs.vh"
module asq_input_decode (
   input  wire [15:0] i_cfg,
   output wire [2:0]  o_gain,
   output wire        o_pos_internal,
   output wire [2:0]  o_pos_external,
   output wire [2:0]  o_pos_source,
   output wire [1:0]  o_neg_select
);
   wire [1:0] gain_code;
   wire [3:0] pos_code;

   assign gain_code = i_cfg[`ASQ_GAIN_HI:`ASQ_GAIN_LO];
   assign pos_code  = i_cfg[`ASQ_POS_HI:`ASQ_POS_LO];

   // Gain one-hot: bit0 x1, bit1 x2, bit2 x4; codes 10b and 11b both give x4.
   assign o_gain = (gain_code == 2'h0) ? 3'h1 :
                   (gain_code == 2'h1) ? 3'h2 : 3'h4;

   assign o_pos_internal = pos_code[3];
   assign o_pos_external = pos_code[2:0];
   // Internal source index 0..7: temp, short, test DAC, analog/4, io/4, digital/2,
   // analog power/103, digital power/103.
   assign o_pos_source = pos_code[2:0];

   assign o_neg_select = pos_code[3] ? `ASQ_NEG_AUTO :
                         (i_cfg[`ASQ_NEG_BIT] ? `ASQ_NEG_IN7 : `ASQ_NEG_GND);
endmodule
`default_nettype wire

// file: design/asq_step_regs.v
// APB register slave for sequencer steps 3 and 4 with step-3 converter controls.
`default_nettype none
`include "asq_defs.vh"
// Function
// - Bit 15 enables step 3, resets 0.
// - Bits 14:13 gain 1, 2, 4, 4.
// - Bit 4 negative input ground or input 7.
// - Bits 3:0 codes 0-7 select external inputs.
// - Internal codes pick negative input automatically.
// - Codes 8-12 map internal sources.
// - Codes 13-15 map supply dividers.
// - Step 3 at 93h, resets 0003h.
// - Step 4 at 94h, resets 0004h.
// - Bits 12:5 reserved, read zero.
module asq_step_regs (
   input  wire        I_CLK,
   input  wire        I_RST_N,
   input  wire        I_PSEL,
   input  wire        I_PENABLE,
   input  wire        I_PWRITE,
   input  wire [11:0] I_PADDR,
   input  wire [31:0] I_PWDATA,
   input  wire [3:0]  I_PSTRB,
   output wire        O_PREADY,
   output reg  [31:0] O_PRDATA,
   output wire        O_PSLVERR,
   output reg         O_STEP3_ENABLE,
   output reg  [2:0]  O_STEP3_GAIN,
   output reg         O_STEP3_POS_INTERNAL,
   output reg  [2:0]  O_STEP3_POS_EXTERNAL,
   output reg  [2:0]  O_STEP3_POS_SOURCE,
   output reg  [1:0]  O_STEP3_NEG_SELECT,
   output wire [15:0] O_STEP4_CONFIG
);
   reg  [15:0] step3_ff;
   reg  [15:0] step4_ff;
   reg  [15:0] nxt_step3;
   reg  [15:0] nxt_step4;
   wire        wr_en;
   wire        hit3;
   wire        hit4;
   wire [15:0] strb_mask;
   wire [2:0]  dec_gain;
   wire        dec_internal;
   wire [2:0]  dec_external;
   wire [2:0]  dec_source;
   wire [1:0]  dec_neg;

   // Register offsets are word indices, so the byte address is four times the index.
   function hit_index;
      input [11:0] addr;
      input [7:0]  idx;
      begin
         hit_index = (addr == {2'h0, idx, 2'h0});
      end
   endfunction

   assign hit3      = hit_index(I_PADDR, `ASQ_STEP3_IDX);
   assign hit4      = hit_index(I_PADDR, `ASQ_STEP4_IDX);
   assign wr_en     = I_PSEL & I_PENABLE & I_PWRITE;
   assign strb_mask = {{8{I_PSTRB[1]}}, {8{I_PSTRB[0]}}};
   assign O_PREADY  = 1'b1;
   // Unmapped addresses answer with an error so software notices a bad pointer.
   assign O_PSLVERR = I_PSEL & I_PENABLE & ~(hit3 | hit4);
   assign O_STEP4_CONFIG = step4_ff;

   always @* begin
      nxt_step3 = step3_ff;
      nxt_step4 = step4_ff;
      if (wr_en && hit3) begin
         // Reserved bits are masked out so they never hold a one.
         nxt_step3 = (step3_ff & ~(strb_mask & `ASQ_WR_MASK)) |
                     (I_PWDATA[15:0] & strb_mask & `ASQ_WR_MASK);
      end
      if (wr_en && hit4) begin
         nxt_step4 = (step4_ff & ~(strb_mask & `ASQ_WR_MASK)) |
                     (I_PWDATA[15:0] & strb_mask & `ASQ_WR_MASK);
      end
   end

   always @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         step3_ff <= `ASQ_STEP3_RST;
         step4_ff <= `ASQ_STEP4_RST;
      end else begin
         step3_ff <= nxt_step3;
         step4_ff <= nxt_step4;
      end
   end

   always @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_PRDATA <= 32'h00000000;
      end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
         if (hit3) begin
            O_PRDATA <= {16'h0000, step3_ff & `ASQ_WR_MASK};
         end else if (hit4) begin
            O_PRDATA <= {16'h0000, step4_ff & `ASQ_WR_MASK};
         end else begin
            O_PRDATA <= 32'h00000000;
         end
      end
   end

   asq_input_decode u_dec (
      .i_cfg          (step3_ff),
      .o_gain         (dec_gain),
      .o_pos_internal (dec_internal),
      .o_pos_external (dec_external),
      .o_pos_source   (dec_source),
      .o_neg_select   (dec_neg)
   );

   // A disabled step drives no selections so the sequencer skips it.
   always @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_STEP3_ENABLE       <= 1'b0;
         O_STEP3_GAIN         <= 3'h0;
         O_STEP3_POS_INTERNAL <= 1'b0;
         O_STEP3_POS_EXTERNAL <= 3'h0;
         O_STEP3_POS_SOURCE   <= 3'h0;
         O_STEP3_NEG_SELECT   <= 2'h0;
      end else begin
         O_STEP3_ENABLE <= step3_ff[`ASQ_EN_BIT];
         if (step3_ff[`ASQ_EN_BIT]) begin
            O_STEP3_GAIN         <= dec_gain;
            O_STEP3_POS_INTERNAL <= dec_internal;
            O_STEP3_POS_EXTERNAL <= dec_internal ? 3'h0 : dec_external;
            O_STEP3_POS_SOURCE   <= dec_internal ? dec_source : 3'h0;
            O_STEP3_NEG_SELECT   <= dec_neg;
         end else begin
            O_STEP3_GAIN         <= 3'h0;
            O_STEP3_POS_INTERNAL <= 1'b0;
            O_STEP3_POS_EXTERNAL <= 3'h0;
            O_STEP3_POS_SOURCE   <= 3'h0;
            O_STEP3_NEG_SELECT   <= 2'h0;
         end
      end
   end
endmodule
`default_nettype wire

// file: shared/asq_defs.vh
// Register map, field positions and reset values of the sequencer step registers.
`ifndef ASQ_DEFS_VH
`define ASQ_DEFS_VH
`define ASQ_STEP3_IDX      8'h93
`define ASQ_STEP4_IDX      8'h94
`define ASQ_STEP3_RST      16'h0003
`define ASQ_STEP4_RST      16'h0004
`define ASQ_EN_BIT         15
`define ASQ_GAIN_HI        14
`define ASQ_GAIN_LO        13
`define ASQ_NEG_BIT        4
`define ASQ_POS_HI         3
`define ASQ_POS_LO         0
`define ASQ_WR_MASK        16'hE01F
`define ASQ_NEG_AUTO       2'h2
`define ASQ_NEG_GND        2'h0
`define ASQ_NEG_IN7        2'h1
`endif

// file: tb/asq_step_regs_props.sv
// Port checks for the sequencer step register slave.
`default_nettype none
module asq_step_regs_props (
   input wire logic        I_CLK,
   input wire logic        I_RST_N,
   input wire logic        I_PSEL,
   input wire logic        I_PENABLE,
   input wire logic        I_PWRITE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [3:0]  I_PSTRB,
   input wire logic        O_PSLVERR,
   input wire logic [31:0] O_PRDATA,
   input wire logic        O_STEP3_ENABLE,
   input wire logic [2:0]  O_STEP3_GAIN,
   input wire logic        O_STEP3_POS_INTERNAL,
   input wire logic [1:0]  O_STEP3_NEG_SELECT
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   wire logic acc = I_PSEL && I_PENABLE;
   wire logic hit = I_PADDR == 12'h24C || I_PADDR == 12'h250;
   wire logic wr3 = acc && I_PWRITE && I_PADDR == 12'h24C && I_PSTRB[1];
   a_err_unmapped: assert property (acc && !hit |-> O_PSLVERR)
      else $error("no error flag");
   a_err_mapped: assert property (acc && hit |-> !O_PSLVERR)
      else $error("false error flag");
   a_rsv_zero: assert property (acc && !I_PWRITE |-> (O_PRDATA & 32'hFFFF1FE0) == 32'h0)
      else $error("reserved bits set");
   a_en_follow: assert property (wr3 |-> ##2 O_STEP3_ENABLE == $past(I_PWDATA[15], 2))
      else $error("enable wrong");
   a_gain_code: assert property (wr3 && I_PWDATA[15] |-> ##2 O_STEP3_GAIN ==
      ($past(I_PWDATA[14], 2) ? 3'h4 : $past(I_PWDATA[13], 2) ? 3'h2 : 3'h1))
      else $error("gain wrong");
   a_neg_auto: assert property (O_STEP3_POS_INTERNAL |-> O_STEP3_NEG_SELECT == 2'h2)
      else $error("negative not automatic");
   a_ext_neg: assert property (O_STEP3_ENABLE && !O_STEP3_POS_INTERNAL |-> !O_STEP3_NEG_SELECT[1])
      else $error("negative select wrong");
   a_off_zero: assert property (!O_STEP3_ENABLE |-> O_STEP3_GAIN == 3'h0)
      else $error("disabled step drives gain");
endmodule
`default_nettype wire

// file: tb/asq_step_regs_tb_top.sv
// Self-checking bench for the sequencer step register slave.
`default_nettype none
module asq_step_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        I_CLK = '0, I_RST_N = '0, I_PSEL = '0, I_PENABLE = '0, I_PWRITE = '0;
   logic [11:0] I_PADDR = '0;
   logic [31:0] I_PWDATA = '0, O_PRDATA, r;
   logic [3:0]  I_PSTRB = '0;
   logic        O_PREADY, O_PSLVERR, O_STEP3_ENABLE, O_STEP3_POS_INTERNAL;
   logic [2:0]  O_STEP3_GAIN, O_STEP3_POS_EXTERNAL, O_STEP3_POS_SOURCE, g;
   logic [1:0]  O_STEP3_NEG_SELECT;
   logic [15:0] O_STEP4_CONFIG;
   int          n_errors = 0, num_checks = 0;
   asq_step_regs u_asq_step_regs (.*);
   initial forever #4 I_CLK = ~I_CLK;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // The request is held until pready is seen high, however long that takes.
   task automatic xfer(input logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
      @(posedge I_CLK);
      I_PSEL <= 1'h1;
      I_PWRITE <= w;
      I_PADDR <= a;
      I_PWDATA <= d;
      I_PSTRB <= s;
      @(posedge I_CLK);
      I_PENABLE <= 1'h1;
      do @(posedge I_CLK); while (O_PREADY !== 1'h1);
      r = O_PRDATA;
      I_PSEL <= 1'h0;
      I_PENABLE <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      xfer(1'h0, a, 32'h0, 4'h0);
      chk(r, e);
   endtask
   task automatic step(input logic [12:0] e);
      repeat (2) @(posedge I_CLK);
      #1 chk({O_STEP3_ENABLE, O_STEP3_GAIN, O_STEP3_POS_INTERNAL, O_STEP3_POS_EXTERNAL,
         O_STEP3_POS_SOURCE, O_STEP3_NEG_SELECT}, {19'h0, e});
   endtask
   task automatic give_verdict;
      $display("errors=%0d checks=%0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge I_CLK);
      I_RST_N <= 1'h1;
      rd(12'h24C, 32'h3);
      rd(12'h250, 32'h4);
      step(13'h0);
      for (int c = 0; c < 16; c++) begin
         g = 3'h1 << (c[1] ? 2 : c[0]);
         xfer(1'h1, 12'h24C, {16'h0, 1'h1, c[1:0], 8'hFF, c[0], c[3:0]}, 4'h3);
         rd(12'h24C, {16'h0, 1'h1, c[1:0], 8'h0, c[0], c[3:0]});
         step({1'h1, g, c[3], c[3] ? 3'h0 : c[2:0], c[3] ? c[2:0] : 3'h0,
            c[3] ? 2'h2 : {1'h0, c[0]}});
      end
      // Only the low byte lane is written; the enable and gain must survive.
      xfer(1'h1, 12'h24C, 32'h0, 4'h1);
      rd(12'h24C, 32'hE000);
      step(13'h1800);
      xfer(1'h1, 12'h24C, 32'h0, 4'h3);
      step(13'h0);
      xfer(1'h1, 12'h250, 32'hFFFF, 4'h3);
      rd(12'h250, 32'hE01F);
      chk({16'h0, O_STEP4_CONFIG}, 32'hE01F);
      xfer(1'h1, 12'h254, 32'hFFFF, 4'h3);
      rd(12'h254, 32'h0);
      give_verdict;
   end
   initial begin
      #50us;
      n_errors++;
      give_verdict;
   end
endmodule
bind asq_step_regs asq_step_regs_props u_asq_step_regs_props (.*);
`default_nettype wire
